// ### design/ebtpm_edge.sv
// Falling-edge detector for the event input pin
`timescale 1ns/1ns
module ebtpm_edge
	import ebtpm_pkg::*;
(
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic event_in_pin,
	output wire logic falling
);

	logic pin_prev;

	// Reset low so a pin held low at release gives no false edge
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_prev <= 1'b0;
		end else begin
			pin_prev <= event_in_pin;
		end
	end

	assign falling = pin_prev & ~event_in_pin; // R6

endmodule : ebtpm_edge

// ### design/ebtpm_prescaler.sv
// Free-running prescaler giving one-cycle ticks at each tap
`timescale 1ns/1ns
module ebtpm_prescaler
	import ebtpm_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   reset,
	input  wire logic   low_clock_tick,
	output ebtpm_taps_s taps
);

	logic [PRE_W-1:0]    pre_cnt;
	logic [FS_DIV_W-1:0] fs_cnt;

	always_ff @(posedge clk) begin
		if (reset) begin
			pre_cnt <= '0;
			fs_cnt  <= '0;
		end else begin
			pre_cnt <= pre_cnt + 1'b1;
			if (low_clock_tick) begin
				fs_cnt <= fs_cnt + 1'b1;
			end
		end
	end

	// A tap fires when all bits below its divide position are ones
	for (genvar g = 0; g < N_TAPS; g++) begin : g_tap
		assign taps.fast[g] = &pre_cnt[TAP_EXP[g]-1:0]; // R5
	end

	assign taps.low      = low_clock_tick;
	assign taps.low_div8 = low_clock_tick & (&fs_cnt);

endmodule : ebtpm_prescaler

// ### design/ebtpm_timer.sv
// Eight-bit timer/counter channel with APB register access
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module ebtpm_timer
	import ebtpm_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              event_in_pin,
	input  wire logic              low_clock_tick,
	output logic                   channel_match_irq,
	output wire logic              divider_out_pin,
	output wire logic              pwm_out_pin
);

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction : hit

	// Tap legality per mode; low speed leaves only the slow clock taps
	function automatic logic pick_tick(
		input ebtpm_clk_e  sel,
		input ebtpm_mode_e md,
		input logic        tapsel,
		input logic        lowspd,
		input ebtpm_taps_s tp,
		input logic        evt
	);
		logic slow;
		logic pwm;
		slow = tapsel | lowspd;
		pwm  = (md == MODE_PWM);
		case (sel)
			CLK_SLOW:   pick_tick = slow ? tp.low_div8 : tp.fast[TAP_DIV2048];
			CLK_DIV128: pick_tick = ~lowspd & tp.fast[TAP_DIV128];
			CLK_DIV32:  pick_tick = ~lowspd & tp.fast[TAP_DIV32];
			CLK_DIV8:   pick_tick = ~lowspd & tp.fast[TAP_DIV8];
			CLK_LOW:    pick_tick = pwm & tp.low;
			CLK_HALF:   pick_tick = pwm & ~lowspd & tp.fast[TAP_DIV2];
			CLK_FULL:   pick_tick = pwm & ~lowspd;
			CLK_PIN:    pick_tick = (md == MODE_TIMER) & evt;
			default:    pick_tick = 1'b0;
		endcase
	endfunction : pick_tick

	logic [CNT_W-1:0] channel_control_reg;
	logic [CNT_W-1:0] match_compare_reg;
	logic [CNT_W-1:0] pwm_duty_staged;
	logic [CNT_W-1:0] pwm_duty_reg;
	logic             duty_pending;
	logic [CFG_W-1:0] cfg_reg;
	logic [CNT_W-1:0] cnt;
	logic             out_level_n;
	ebtpm_state_e     state;
	ebtpm_taps_s      taps;

	wire logic        evt_fall;
	wire logic        setup_ph = psel & ~penable;
	wire logic        wr_en    = psel & penable & pwrite & pready;
	wire logic        wr_ctrl  = wr_en & hit(paddr, OFF_CTRL);
	wire logic        wr_cmp   = wr_en & hit(paddr, OFF_CMP);
	wire logic        wr_duty  = wr_en & hit(paddr, OFF_DUTY);
	wire logic        wr_cfg   = wr_en & hit(paddr, OFF_CFG);
	wire logic        mapped   = hit(paddr, OFF_CTRL) | hit(paddr, OFF_CMP) | hit(paddr, OFF_DUTY)
	                           | hit(paddr, OFF_STAT) | hit(paddr, OFF_CFG);

	wire ebtpm_clk_e  clk_sel  = ebtpm_clk_e'(channel_control_reg[CTRL_CLK_LSB +: SEL_W]);
	wire ebtpm_mode_e mode     = ebtpm_mode_e'(channel_control_reg[CTRL_MODE_LSB +: SEL_W]);
	wire logic        running  = (state == ST_RUNNING);
	wire logic        new_start     = pwdata[CTRL_START_BIT];
	wire logic        flipflop_preset_bit  = pwdata[CTRL_PRESET_BIT];
	wire logic        prescaler_tap_select = cfg_reg[CFG_TAPSEL_BIT];
	wire logic        low_speed     = cfg_reg[CFG_LOWSPD_BIT];

	wire logic        tick     = running & pick_tick(clk_sel, mode, prescaler_tap_select, low_speed,
	                                                 taps, evt_fall); // R5 R20
	wire logic [CNT_W-1:0] cnt_plus = cnt + CNT_ONE;
	wire logic        is_pwm   = (mode == MODE_PWM);
	wire logic        cmp_hit  = tick & ~is_pwm & (cnt_plus == match_compare_reg); // R1 R3 R6
	wire logic        ovf_hit  = tick & is_pwm & (cnt == CNT_MAX); // R14
	wire logic        duty_hit = tick & is_pwm & ~ovf_hit & (cnt_plus == pwm_duty_reg); // R14
	wire logic        period   = cmp_hit | ovf_hit;
	wire logic        toggle   = (cmp_hit & (mode == MODE_DIVIDER)) | ovf_hit | duty_hit; // R8 R14

	logic [DATA_W-1:0] rd_mux;
	logic [CNT_W-1:0]  next_cnt;
	logic              next_out_level_n;
	logic [CNT_W-1:0]  next_duty_active;

	ebtpm_prescaler u_prescaler (
		.clk            (clk),
		.reset          (reset),
		.low_clock_tick (low_clock_tick),
		.taps           (taps)
	);

	ebtpm_edge u_edge (
		.clk          (clk),
		.reset        (reset),
		.event_in_pin (event_in_pin),
		.falling      (evt_fall)
	);

	// Read data: duty shows the active value, not the staged one
	always_comb begin
		rd_mux = '0;
		case (1'b1)
			hit(paddr, OFF_CTRL): rd_mux[CNT_W-1:0] = channel_control_reg;
			hit(paddr, OFF_CMP):  rd_mux[CNT_W-1:0] = match_compare_reg;
			hit(paddr, OFF_DUTY): rd_mux[CNT_W-1:0] = pwm_duty_reg; // R17
			hit(paddr, OFF_STAT): begin
				rd_mux[STAT_CNT_LSB +: CNT_W] = cnt;
				rd_mux[STAT_FF_BIT]           = ~out_level_n;
				rd_mux[STAT_RUN_BIT]          = running;
				rd_mux[STAT_PEND_BIT]         = duty_pending;
			end
			hit(paddr, OFF_CFG):  rd_mux[CFG_W-1:0] = cfg_reg;
			default:              rd_mux = '0;
		endcase
	end

	// Counter: cleared while stopped, on match and on PWM overflow
	always_comb begin
		next_cnt = cnt;
		if (!running || (wr_ctrl && !new_start)) begin
			next_cnt = CNT_ZERO; // R22
		end else if (period) begin
			next_cnt = CNT_ZERO; // R1 R6 R8 R14
		end else if (tick) begin
			next_cnt = cnt_plus; // R22
		end
	end

	// Output flip-flop held inverted, so the pins are the flop itself
	always_comb begin
		next_out_level_n = out_level_n;
		if (wr_ctrl && !running) begin
			next_out_level_n = ~flipflop_preset_bit; // R12 R15
		end else if (wr_ctrl && !new_start) begin
			next_out_level_n = out_level_n; // R11
		end else if (toggle) begin
			next_out_level_n = ~out_level_n; // R8 R14
		end
	end

	// A duty write in the same cycle as the period takes the new value
	always_comb begin
		next_duty_active = pwm_duty_reg;
		if (wr_duty && (!running || period)) begin
			next_duty_active = pwdata[CNT_W-1:0]; // R16
		end else if (period && duty_pending) begin
			next_duty_active = pwm_duty_staged; // R16
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~mapped;
			prdata  <= (setup_ph & ~pwrite) ? rd_mux : '0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			channel_control_reg <= CTRL_RESET;
			state               <= ST_STOPPED;
		end else if (wr_ctrl) begin
			channel_control_reg <= pwdata[CNT_W-1:0]; // R13
			state               <= new_start ? ST_RUNNING : ST_STOPPED; // R12
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			match_compare_reg <= CMP_RESET;
			cfg_reg           <= CFG_RESET;
		end else begin
			if (wr_cmp) begin
				match_compare_reg <= pwdata[CNT_W-1:0]; // R3
			end
			if (wr_cfg) begin
				cfg_reg <= pwdata[CFG_W-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pwm_duty_staged <= DUTY_RESET;
			pwm_duty_reg    <= DUTY_RESET;
			duty_pending    <= 1'b0;
		end else begin
			if (wr_duty) begin
				pwm_duty_staged <= pwdata[CNT_W-1:0]; // R16
			end
			pwm_duty_reg <= next_duty_active;
			duty_pending <= wr_duty ? (running & ~period) : (duty_pending & ~period);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt               <= CNT_ZERO;
			out_level_n       <= 1'b1; // R9
			channel_match_irq <= 1'b0;
		end else begin
			cnt               <= next_cnt;
			out_level_n       <= next_out_level_n;
			channel_match_irq <= period; // R1 R6 R8 R14
		end
	end

	assign divider_out_pin = out_level_n; // R9
	assign pwm_out_pin     = out_level_n; // R15

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	timer_match_clear_a: assert property ( // R1
		(running && tick && mode == MODE_TIMER && cnt_plus == match_compare_reg && !wr_ctrl)
		|=> (cnt == CNT_ZERO) && channel_match_irq)
		else $error("timer match did not clear counter and interrupt");

	compare_direct_a: assert property ( // R3
		(wr_cmp && running && !is_pwm && tick) ##1 (running && tick && !wr_ctrl
			&& cnt_plus == match_compare_reg) |=> channel_match_irq)
		else $error("new compare value not used at once");

	low_speed_tap_a: assert property ( // R5
		(low_speed && clk_sel inside {CLK_DIV128, CLK_DIV32, CLK_DIV8, CLK_HALF, CLK_FULL}) |-> !tick)
		else $error("fast tap ticked in low speed mode");

	event_count_a: assert property ( // R6
		(running && !wr_ctrl && mode == MODE_TIMER && clk_sel == CLK_PIN && !evt_fall)
		|=> (cnt == $past(cnt)))
		else $error("event counter moved without a falling edge");

	divider_toggle_a: assert property ( // R8
		(cmp_hit && mode == MODE_DIVIDER && !wr_ctrl)
		|=> (divider_out_pin != $past(divider_out_pin)) && channel_match_irq)
		else $error("divider match did not toggle output");

	reset_level_a: assert property ( // R9
		$past(reset) |-> divider_out_pin && pwm_out_pin && !channel_match_irq)
		else $error("output flip-flop not cleared by reset");

	stop_hold_a: assert property ( // R11
		(running && wr_ctrl && !new_start) |=> $stable(divider_out_pin) && (cnt == CNT_ZERO))
		else $error("pin changed when counter stopped");

	preset_low_a: assert property ( // R12
		(!running && wr_ctrl && !flipflop_preset_bit) |=> divider_out_pin ##1 (divider_out_pin || toggle
			|| $past(wr_ctrl)))
		else $error("clearing preset did not drive pin high");

	pwm_overflow_a: assert property ( // R14
		(ovf_hit && !wr_ctrl) |=> (cnt == CNT_ZERO) && channel_match_irq && $changed(pwm_out_pin))
		else $error("pwm overflow did not clear, toggle and interrupt");

	duty_staged_a: assert property ( // R16
		(running && wr_duty && !period) ##1 (!period [*2]) |-> $stable(pwm_duty_reg))
		else $error("duty moved before period end");

	duty_stopped_a: assert property ( // R16
		(!running && wr_duty) |=> (pwm_duty_reg == $past(pwdata[CNT_W-1:0])))
		else $error("duty write while stopped not taken at once");

	apb_answer_a: assert property (
		(psel && !penable) |=> pready ##1 !pready)
		else $error("apb answer not one cycle after setup");

	unmapped_error_a: assert property (
		(setup_ph && !mapped) |=> pslverr && (prdata == '0))
		else $error("unmapped address not refused");

	ready_setup_a: assert property (
		pready |-> $past(setup_ph))
		else $error("ready without a setup cycle");

	// Read data is registered, so it must fall back to zero outside the answer cycle
	prdata_idle_a: assert property (
		!pready |-> (prdata == '0))
		else $error("read data not zero outside answer");

	control_decode_a: assert property ( // R13
		wr_ctrl |=> (clk_sel == $past(pwdata[CTRL_CLK_LSB +: SEL_W]))
			&& (mode == $past(pwdata[CTRL_MODE_LSB +: SEL_W])) && (running == $past(new_start)))
		else $error("control word not decoded into clock, mode and start");

	irq_pulse_a: assert property ( // R1
		channel_match_irq |=> !channel_match_irq)
		else $error("interrupt pulse longer than one cycle");

	timer_pin_hold_a: assert property ( // R1
		(running && mode == MODE_TIMER && !wr_ctrl) |=> $stable(divider_out_pin))
		else $error("pin moved in timer mode");

	event_step_a: assert property ( // R6
		(running && !wr_ctrl && mode == MODE_TIMER && clk_sel == CLK_PIN && evt_fall && !cmp_hit)
		|=> (cnt == $past(cnt) + CNT_ONE))
		else $error("falling edge did not advance event counter");

	pwm_preset_a: assert property ( // R15
		(wr_ctrl && !running) |=> (pwm_out_pin == !$past(flipflop_preset_bit)))
		else $error("preset bit did not set pwm level");

	duty_transfer_a: assert property ( // R16
		(period && duty_pending && !wr_duty) |=> (pwm_duty_reg == $past(pwm_duty_staged)))
		else $error("staged duty not moved at period end");

	duty_read_a: assert property ( // R17
		(setup_ph && !pwrite && hit(paddr, OFF_DUTY))
		|=> (prdata == {{(DATA_W-CNT_W){1'b0}}, $past(pwm_duty_reg)}))
		else $error("duty read did not show active value");

	// Undivided sources are legal only for pwm; low speed drops the fast one
	full_clock_a: assert property ( // R20
		(running && is_pwm && clk_sel == CLK_FULL && !low_speed) |-> tick)
		else $error("undivided fast clock did not tick in pwm");

	low_clock_a: assert property ( // R20
		(running && is_pwm && clk_sel == CLK_LOW) |-> (tick == low_clock_tick))
		else $error("low clock not followed in pwm");

	stopped_zero_a: assert property ( // R22
		!running |-> (cnt == CNT_ZERO))
		else $error("counter not zero while stopped");

	pwm_period_c: cover property (ovf_hit ##1 channel_match_irq);
	divider_match_c: cover property (cmp_hit && mode == MODE_DIVIDER);
	event_match_c: cover property (cmp_hit && clk_sel == CLK_PIN);
	duty_transfer_c: cover property (duty_pending && period);
	half_clock_c: cover property (ovf_hit && clk_sel == CLK_HALF);

endmodule : ebtpm_timer

// ### include/ebtpm_pkg.sv
// Constants, field layout and types of the eight-bit timer/counter channel
// Function
// (R1) Timer mode counts, matches, interrupts, clears, continues
// (R2) Software keeps preset zero in timer modes
// (R3) Compare register unbuffered, effective next cycle
// (R4) Software never rewrites compare while running
// (R5) Tap choices fixed; low speed allows low/8
// (R6) Event mode counts falling edges, match clears
// (R7) Event phases last at least two cycles
// (R8) Divider match toggles flip-flop, clears, interrupts
// (R9) Divider pin inverse of flip-flop, reset zero
// (R10) Software sets port latch before pin use
// (R11) Stop holds pin level; preset later
// (R12) Bit 3 starts; bit 7 presets when stopped
// (R13) Control words select tap, mode, start
// (R14) PWM: duty toggles, overflow toggles, clears, interrupts
// (R15) PWM pin inverse; preset chooses pulse polarity
// (R16) Duty staged while running, immediate when stopped
// (R17) Duty read shows active value until period
// (R18) Software writes duty soon after period interrupt
// (R19) Software stops counter before stop mode
// (R20) PWM also accepts low, half, full clock
// (R21) Software keeps compare and duty in range
// (R22) Counter eight bits, zero when stopped, wraps
package ebtpm_pkg;

	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam int          CNT_W         = 8;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CMP  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_DUTY = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_CFG  = 8'h10;

	// Control word layout
	localparam int CTRL_PRESET_BIT = 7;
	localparam int CTRL_CLK_LSB    = 4;
	localparam int CTRL_START_BIT  = 3;
	localparam int CTRL_MODE_LSB   = 0;
	localparam int SEL_W           = 3;

	// Status and configuration layout
	localparam int STAT_CNT_LSB    = 0;
	localparam int STAT_FF_BIT     = 8;
	localparam int STAT_RUN_BIT    = 9;
	localparam int STAT_PEND_BIT   = 10;
	localparam int CFG_TAPSEL_BIT  = 0;
	localparam int CFG_LOWSPD_BIT  = 1;
	localparam int CFG_W           = 2;

	// Reset values
	localparam logic [CNT_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [CNT_W-1:0] CMP_RESET  = 8'h00;
	localparam logic [CNT_W-1:0] DUTY_RESET = 8'h00;
	localparam logic [CFG_W-1:0] CFG_RESET  = 2'h0;
	localparam logic [CNT_W-1:0] CNT_ZERO   = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE    = 8'h01;
	localparam logic [CNT_W-1:0] CNT_MAX    = 8'hff;

	// Prescaler taps of the fast clock: divide by 2^exp
	localparam int PRE_W     = 11;
	localparam int FS_DIV_W  = 3;
	localparam int N_TAPS    = 5;
	localparam int TAP_EXP [N_TAPS] = '{1, 3, 5, 7, 11};
	localparam int TAP_DIV2    = 0;
	localparam int TAP_DIV8    = 1;
	localparam int TAP_DIV32   = 2;
	localparam int TAP_DIV128  = 3;
	localparam int TAP_DIV2048 = 4;

	typedef enum logic [SEL_W-1:0] {
		CLK_SLOW, CLK_DIV128, CLK_DIV32, CLK_DIV8, CLK_LOW, CLK_HALF, CLK_FULL, CLK_PIN
	} ebtpm_clk_e;

	typedef enum logic [SEL_W-1:0] {
		MODE_TIMER, MODE_DIVIDER, MODE_PWM, MODE_RSV3, MODE_RSV4, MODE_RSV5, MODE_RSV6, MODE_RSV7
	} ebtpm_mode_e;

	typedef enum logic {
		ST_STOPPED, ST_RUNNING
	} ebtpm_state_e;

	typedef struct packed {
		logic [N_TAPS-1:0] fast;
		logic              low;
		logic              low_div8;
	} ebtpm_taps_s;

endpackage : ebtpm_pkg

// ### test/ebtpm_src.sv
// Far-side model: event source on the count pin and low-clock tick source
`timescale 1ns/1ns
module ebtpm_src (
	input  wire logic clk,
	output logic      event_in_pin,
	output logic      low_clock_tick
);
	logic [2:0] div = 3'h0;

	initial begin
		event_in_pin = 1'b1;
	end

	// Low clock modelled as one tick in eight cycles, unrelated to any start write
	always @(posedge clk) begin
		div <= div + 3'h1;
		low_clock_tick <= (div == 3'h7);
	end

	// Phases held three cycles each, above the two-cycle minimum
	task automatic falls(input int n);
		repeat (n) begin
			repeat (3) @(posedge clk);
			event_in_pin <= 1'b0;
			repeat (3) @(posedge clk);
			event_in_pin <= 1'b1;
		end
	endtask : falls
endmodule : ebtpm_src

// ### test/ebtpm_timer_tb.sv
// Self-checking bench of the eight-bit timer channel
`timescale 1ns/1ns
module ebtpm_timer_tb
	import ebtpm_pkg::*;
;
	logic              clk;
	logic              reset;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata;
	logic [DATA_W-1:0] prdata;
	logic              pready;
	logic              pslverr;
	logic              irq;
	wire logic         div_pin;
	wire logic         pwm_pin;
	wire logic         evt;
	wire logic         low_tick;
	logic [31:0]       rd;
	logic              err;
	int                num_errors;
	int                check_count;
	int                irq_count;
	int                n;
	int                lo;
	int                i0;

	ebtpm_timer u_dut (
		.clk               (clk),
		.reset             (reset),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.event_in_pin      (evt),
		.low_clock_tick    (low_tick),
		.channel_match_irq (irq),
		.divider_out_pin   (div_pin),
		.pwm_out_pin       (pwm_pin)
	);

	ebtpm_src u_src (
		.clk            (clk),
		.event_in_pin   (evt),
		.low_clock_tick (low_tick)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		if (irq === 1'b1) irq_count++;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Entered just after an edge; request held until pready is seen high
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int t;
		t = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		if (pready !== 1'b1) begin
			num_errors++;
			$display("unexpected pready expected 1 seen %b", pready);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask : rdchk

	// Edges up to the next interrupt pulse, and how many of them saw the pin low
	task automatic next_irq();
		n = 0;
		lo = 0;
		do begin
			@(posedge clk);
			n++;
			if (pwm_pin === 1'b0) lo++;
		end while (irq !== 1'b1 && n < 5000);
		if (irq !== 1'b1) begin
			num_errors++;
			$display("unexpected interrupt expected 1 seen %b", irq);
		end
	endtask : next_irq

	task automatic close_out();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	initial begin
		#(20 * 20000);
		num_errors++;
		$display("unexpected run time expected done seen timeout");
		close_out();
	end

	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		num_errors = 0;
		check_count = 0;
		irq_count = 0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		chk("divider pin", 32'h1, {31'h0, div_pin});
		rdchk("ctrl", OFF_CTRL, 32'h0);
		rdchk("cmp", OFF_CMP, 32'h0);
		rdchk("duty", OFF_DUTY, 32'h0);
		rdchk("stat", OFF_STAT, 32'h0);
		rdchk("cfg", OFF_CFG, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		wr(OFF_CMP, 32'h2);
		wr(OFF_CTRL, 32'h10);
		rdchk("ctrl", OFF_CTRL, 32'h10);
		wr(OFF_CTRL, 32'h18);
		next_irq();
		next_irq();
		chk("timer period", 32'd256, 32'(n));
		chk("pin in timer", 32'h1, {31'h0, div_pin});
		wr(OFF_CTRL, 32'h10);
		wr(OFF_CFG, 32'h1);
		wr(OFF_CTRL, 32'h08);
		next_irq();
		next_irq();
		chk("slow tap period", 32'd128, 32'(n));
		wr(OFF_CTRL, 32'h00);
		wr(OFF_CFG, 32'h0);
		wr(OFF_CMP, 32'h1);
		wr(OFF_CTRL, 32'h38);
		next_irq();
		next_irq();
		chk("new compare period", 32'd8, 32'(n));
		wr(OFF_CTRL, 32'h30);
		wr(OFF_CMP, 32'h3);
		wr(OFF_CTRL, 32'h11);
		wr(OFF_CTRL, 32'h19);
		next_irq();
		chk("divider pin", 32'h0, {31'h0, div_pin});
		next_irq();
		chk("divider half period", 32'd384, 32'(n));
		chk("divider pin", 32'h1, {31'h0, div_pin});
		next_irq();
		// Stop first, preset only in a later write
		wr(OFF_CTRL, 32'h11);
		repeat (400) @(posedge clk);
		chk("held pin", 32'h0, {31'h0, div_pin});
		rdchk("stat stopped", OFF_STAT, 32'h100);
		wr(OFF_CTRL, 32'h01);
		chk("preset low", 32'h1, {31'h0, div_pin});
		wr(OFF_CTRL, 32'h81);
		chk("preset high", 32'h0, {31'h0, div_pin});
		wr(OFF_CTRL, 32'h01);
		wr(OFF_CTRL, 32'h78);
		u_src.falls(2);
		repeat (2) @(posedge clk);
		rdchk("event count", OFF_STAT, 32'h202);
		i0 = irq_count;
		u_src.falls(1);
		repeat (3) @(posedge clk);
		chk("event irq", 32'h1, 32'(irq_count - i0));
		rdchk("event cleared", OFF_STAT, 32'h200);
		wr(OFF_CTRL, 32'h70);
		wr(OFF_DUTY, 32'h40);
		rdchk("duty stopped", OFF_DUTY, 32'h40);
		wr(OFF_CTRL, 32'h6a);
		next_irq();
		next_irq();
		chk("pwm period", 32'd256, 32'(n));
		chk("pwm low", 32'd192, 32'(lo));
		wr(OFF_DUTY, 32'h80);
		rdchk("duty old", OFF_DUTY, 32'h40);
		apb(1'b0, OFF_STAT, 32'h0);
		chk("pwm running", 32'h1, {31'h0, rd[STAT_RUN_BIT]});
		chk("duty pending", 32'h1, {31'h0, rd[STAT_PEND_BIT]});
		next_irq();
		rdchk("duty new", OFF_DUTY, 32'h80);
		next_irq();
		chk("pwm low", 32'd128, 32'(lo));
		wr(OFF_CTRL, 32'h62);
		wr(OFF_DUTY, 32'h40);
		wr(OFF_CTRL, 32'he2);
		chk("pwm preset", 32'h0, {31'h0, pwm_pin});
		wr(OFF_CTRL, 32'hea);
		next_irq();
		next_irq();
		chk("pwm inverted low", 32'd64, 32'(lo));
		wr(OFF_CTRL, 32'h62);
		chk("held pwm pin", 32'h0, {31'h0, pwm_pin});
		wr(OFF_CTRL, 32'h5a);
		next_irq();
		next_irq();
		chk("half clock period", 32'd512, 32'(n));
		chk("half clock low", 32'd384, 32'(lo));
		wr(OFF_CTRL, 32'h52);
		wr(OFF_CFG, 32'h2);
		wr(OFF_CTRL, 32'h5a);
		repeat (600) @(posedge clk);
		rdchk("low speed tap", OFF_STAT, 32'h200);
		close_out();
	end
endmodule : ebtpm_timer_tb
